// ### hw/eda_regs.vh
// Register offsets, field positions, reset values and timing counts of the
// external request acceptance block.
// Assumes a 4-bit register index on the plain register port.
`ifndef EDA_REGS_VH
`define EDA_REGS_VH

// ---------------------------------------------------------------------------
// Register indices
// ---------------------------------------------------------------------------
`define EDA_ADDR_W 4
`define EDA_OFS_MODE 4'h0
`define EDA_OFS_COUNT 4'h1
`define EDA_OFS_DRAMC 4'h2
`define EDA_OFS_BUSC 4'h3
`define EDA_OFS_STAT 4'h4

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define EDA_MODE_ENABLE 0
`define EDA_MODE_NRD 1
`define EDA_DRAMC_PAGE 0
`define EDA_DRAMC_INT_FULL 1
`define EDA_DRAMC_EXT_FULL 2
`define EDA_BUSC_INT_ACK 0
`define EDA_BUSC_EXT_ACK 1
`define EDA_STAT_ENABLE 0
`define EDA_STAT_HELD 1
`define EDA_STAT_OPEN 2
`define EDA_STAT_CNT_LSB 16

// ---------------------------------------------------------------------------
// Reset values and widths
// ---------------------------------------------------------------------------
`define EDA_CNT_W 16
`define EDA_RST_COUNT 16'h0000
`define EDA_RST_STROBE 3'h7

// ---------------------------------------------------------------------------
// Strobe timing counts, in bus clock cycles
// ---------------------------------------------------------------------------
`define EDA_BS_POS_PAGE 2'h0
`define EDA_BS_POS_FULL 2'h1
`define EDA_ACK_LATE 2'h1

`endif

// ### hw/eda_buf2.v
// Two-entry valid/ready buffer for activation words.
// Assumes both sides run on clk_sys_i; the output side is fully registered.
`timescale 1ns/100ps

module eda_buf2 #(
	parameter W = 16
) (
	input wire clk_sys_i,
	input wire srst_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [W-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [W-1:0] out_data_o
);

	reg out_valid_ff;
	reg [W-1:0] out_data_ff;
	reg skid_valid_ff;
	reg [W-1:0] skid_data_ff;
	wire take;
	wire drain;

	// The input is refused only while the spare entry is occupied.
	assign in_ready_o = ~skid_valid_ff;
	assign out_valid_o = out_valid_ff;
	assign out_data_o = out_data_ff;
	assign take = in_valid_i & ~skid_valid_ff;
	assign drain = out_ready_i | ~out_valid_ff;

	// The head entry refills from the spare first, so order is kept.
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			out_valid_ff <= 1'b0;
			out_data_ff <= {W{1'b0}};
			skid_valid_ff <= 1'b0;
			skid_data_ff <= {W{1'b0}};
		end else if (drain) begin
			if (skid_valid_ff) begin
				out_valid_ff <= 1'b1;
				out_data_ff <= skid_data_ff;
				skid_valid_ff <= 1'b0;
			end else begin
				out_valid_ff <= take;
				out_data_ff <= in_data_i;
			end
		end else if (take) begin
			skid_valid_ff <= 1'b1;
			skid_data_ff <= in_data_i;
		end
	end

endmodule

// ### hw/eda_req_accept.v
// External request acceptance for cluster transfer mode, with the DRAM
// access choice and the acknowledge and bus-start strobe timing.
// Assumes the channel sequencer and bus controller run on clk_sys_i and
// the request pin arrives asynchronously.
//
// Functional notes
// RULE1 - Sample request pin each cycle after enabling.
// RULE2 - Low sample while open latches a request.
// RULE3 - Activation start clears the held request.
// RULE4 - Delay bit 0: reopen at cluster end.
// RULE5 - Delay bit 1: reopen one cycle later.
// RULE6 - Page mode: select bits choose page/full.
// RULE7 - Page mode off: always full access; bus start and ack timing still follow the select bits.
// RULE8 - Select bits shift ack and start timing.
// RULE9 - Ack timing bits move ack assertion.
// RULE10 - Low level while closed is ignored.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "eda_regs.vh"

module eda_req_accept (
	input wire clk_sys_i,
	input wire srst_i,
	input wire [`EDA_ADDR_W-1:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	input wire ext_xfer_request_n_i,
	input wire cluster_wr_end_i,
	output wire act_valid_o,
	input wire act_ready_i,
	output wire [`EDA_CNT_W-1:0] act_count_o,
	input wire dma_cycle_start_i,
	input wire dma_cycle_int_i,
	input wire dma_cycle_dram_i,
	input wire dma_cycle_end_i,
	output reg fast_page_o,
	output reg bus_start_n_o,
	output reg int_xfer_ack_n_o,
	output reg ext_xfer_ack_n_o
);

	// -----------------------------------------------------------------------
	// Register state
	// -----------------------------------------------------------------------
	reg xfer_enable_bit_ff;
	reg next_request_delay_ff;
	reg [`EDA_CNT_W-1:0] count_ff;
	reg page_mode_enable_ff;
	reg int_full_access_select_ff;
	reg ext_full_access_select_ff;
	reg int_ack_timing_sel_ff;
	reg ext_ack_timing_sel_ff;

	// -----------------------------------------------------------------------
	// Acceptance state
	// -----------------------------------------------------------------------
	reg req_s1_ff;
	reg req_s2_ff;
	reg req_s3_ff;
	reg req_lvl_ff;
	reg accept_open_ff;
	reg held_ff;
	reg reopen_dly_ff;
	wire push_ready;
	wire push;
	wire wr_mode;
	wire wr_count;
	wire last_cluster;

	// -----------------------------------------------------------------------
	// Strobe state
	// -----------------------------------------------------------------------
	reg cyc_active_ff;
	reg cyc_int_ff;
	reg cyc_full_ff;
	reg [1:0] cyc_phase_ff;
	reg nxt_fast_page;
	reg nxt_bus_start_n;
	reg nxt_int_ack_n;
	reg nxt_ext_ack_n;
	reg sel_full;
	reg sel_late;
	reg [1:0] bs_pos;
	reg [1:0] ack_pos;

	assign wr_mode = reg_wr_i & (reg_addr_i == `EDA_OFS_MODE);
	assign wr_count = reg_wr_i & (reg_addr_i == `EDA_OFS_COUNT);
	assign last_cluster = (count_ff == {{(`EDA_CNT_W-1){1'b0}}, 1'b1});

	// -----------------------------------------------------------------------
	// Register writes
	// -----------------------------------------------------------------------

	// Configuration registers; the enable also drops after the last cluster.
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			xfer_enable_bit_ff <= 1'b0;
			next_request_delay_ff <= 1'b0;
			count_ff <= `EDA_RST_COUNT;
			page_mode_enable_ff <= 1'b0;
			int_full_access_select_ff <= 1'b0;
			ext_full_access_select_ff <= 1'b0;
			int_ack_timing_sel_ff <= 1'b0;
			ext_ack_timing_sel_ff <= 1'b0;
		end else begin
			if (wr_mode) begin
				xfer_enable_bit_ff <= reg_wdata_i[`EDA_MODE_ENABLE];
				next_request_delay_ff <= reg_wdata_i[`EDA_MODE_NRD];
			end else if (cluster_wr_end_i & xfer_enable_bit_ff & last_cluster) begin
				xfer_enable_bit_ff <= 1'b0;
			end
			if (wr_count) begin
				count_ff <= reg_wdata_i[`EDA_CNT_W-1:0];
			end else if (cluster_wr_end_i & xfer_enable_bit_ff & (count_ff != `EDA_RST_COUNT)) begin
				count_ff <= count_ff - {{(`EDA_CNT_W-1){1'b0}}, 1'b1};
			end
			if (reg_wr_i & (reg_addr_i == `EDA_OFS_DRAMC)) begin
				page_mode_enable_ff <= reg_wdata_i[`EDA_DRAMC_PAGE];
				int_full_access_select_ff <= reg_wdata_i[`EDA_DRAMC_INT_FULL];
				ext_full_access_select_ff <= reg_wdata_i[`EDA_DRAMC_EXT_FULL];
			end
			if (reg_wr_i & (reg_addr_i == `EDA_OFS_BUSC)) begin
				int_ack_timing_sel_ff <= reg_wdata_i[`EDA_BUSC_INT_ACK];
				ext_ack_timing_sel_ff <= reg_wdata_i[`EDA_BUSC_EXT_ACK];
			end
		end
	end

	// -----------------------------------------------------------------------
	// Register reads
	// -----------------------------------------------------------------------

	// Read data stand only in the cycle after the read strobe.
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`EDA_OFS_MODE: begin
					reg_rdata_o <= {30'h0000_0000, next_request_delay_ff, xfer_enable_bit_ff};
				end
				`EDA_OFS_COUNT: begin
					reg_rdata_o <= {16'h0000, count_ff};
				end
				`EDA_OFS_DRAMC: begin
					reg_rdata_o <= {29'h0000_0000, ext_full_access_select_ff,
						int_full_access_select_ff, page_mode_enable_ff};
				end
				`EDA_OFS_BUSC: begin
					reg_rdata_o <= {30'h0000_0000, ext_ack_timing_sel_ff, int_ack_timing_sel_ff};
				end
				`EDA_OFS_STAT: begin
					reg_rdata_o <= {count_ff, 13'h0000, accept_open_ff, held_ff,
						xfer_enable_bit_ff};
				end
				default: begin
					reg_rdata_o <= 32'h0000_0000;
				end
			endcase
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end

	// -----------------------------------------------------------------------
	// Request pin synchroniser
	// -----------------------------------------------------------------------

	// Three stages; the level moves only when the last two agree.
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			req_s1_ff <= 1'b1;
			req_s2_ff <= 1'b1;
			req_s3_ff <= 1'b1;
			req_lvl_ff <= 1'b1;
		end else begin
			req_s1_ff <= ext_xfer_request_n_i;
			req_s2_ff <= req_s1_ff;
			req_s3_ff <= req_s2_ff;
			if (req_s2_ff == req_s3_ff) begin
				req_lvl_ff <= req_s3_ff;
			end
		end
	end

	// -----------------------------------------------------------------------
	// Request acceptance
	// -----------------------------------------------------------------------

	// Activation starts when the held request enters the buffer.
	assign push = held_ff & push_ready;

	// Acceptance window and held request.
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			accept_open_ff <= 1'b0;
			held_ff <= 1'b0;
			reopen_dly_ff <= 1'b0;
		end else if (wr_mode) begin
			// RULE1 sampling starts after enable write
			accept_open_ff <= reg_wdata_i[`EDA_MODE_ENABLE];
			held_ff <= 1'b0;
			reopen_dly_ff <= 1'b0;
		end else if (~xfer_enable_bit_ff) begin
			accept_open_ff <= 1'b0;
			held_ff <= 1'b0;
			reopen_dly_ff <= 1'b0;
		end else begin
			// RULE2 latch low level
			// RULE10 closed window ignores pin
			if (accept_open_ff & ~req_lvl_ff) begin
				held_ff <= 1'b1;
				accept_open_ff <= 1'b0;
			end else if (push) begin
				// RULE3 clear on activation
				held_ff <= 1'b0;
			end
			reopen_dly_ff <= 1'b0;
			if (cluster_wr_end_i & ~last_cluster) begin
				if (next_request_delay_ff) begin
					// RULE5 reopen one cycle later
					reopen_dly_ff <= 1'b1;
				end else begin
					// RULE4 reopen at cluster end
					accept_open_ff <= 1'b1;
				end
			end
			if (reopen_dly_ff) begin
				accept_open_ff <= 1'b1;
			end
		end
	end

	// Activation words wait here while the sequencer stalls.
	eda_buf2 #(
		.W(`EDA_CNT_W)
	) u_act_buf (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.in_valid_i(held_ff),
		.in_ready_o(push_ready),
		.in_data_i(count_ff),
		.out_valid_o(act_valid_o),
		.out_ready_i(act_ready_i),
		.out_data_o(act_count_o)
	);

	// -----------------------------------------------------------------------
	// DRAM access choice and strobe timing
	// -----------------------------------------------------------------------

	// Bus cycle tracking: phase counts cycles since the cycle start, holding at 3.
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			cyc_active_ff <= 1'b0;
			cyc_int_ff <= 1'b0;
			cyc_full_ff <= 1'b0;
			cyc_phase_ff <= 2'h0;
		end else if (dma_cycle_start_i) begin
			cyc_active_ff <= 1'b1;
			cyc_int_ff <= dma_cycle_int_i;
			cyc_full_ff <= dma_cycle_int_i ? int_full_access_select_ff :
				ext_full_access_select_ff;
			cyc_phase_ff <= 2'h1;
		end else if (dma_cycle_end_i) begin
			cyc_active_ff <= 1'b0;
			cyc_phase_ff <= 2'h0;
		end else if (cyc_active_ff & (cyc_phase_ff != 2'h3)) begin
			cyc_phase_ff <= cyc_phase_ff + 2'h1;
		end
	end

	// Next values of the registered strobes and the access choice.
	always @* begin
		sel_full = dma_cycle_int_i ? int_full_access_select_ff :
			ext_full_access_select_ff;
		sel_late = cyc_int_ff ? int_ack_timing_sel_ff : ext_ack_timing_sel_ff;
		// RULE8 select bits shift timing
		bs_pos = cyc_full_ff ? `EDA_BS_POS_FULL : `EDA_BS_POS_PAGE;
		// RULE9 ack timing selection
		ack_pos = bs_pos + (sel_late ? `EDA_ACK_LATE : 2'h0);
		nxt_fast_page = fast_page_o;
		if (dma_cycle_start_i) begin
			// RULE6 page mode honours select
			// RULE7 no page mode means full
			nxt_fast_page = dma_cycle_dram_i & page_mode_enable_ff & ~sel_full;
		end
		nxt_bus_start_n = 1'b1;
		nxt_int_ack_n = 1'b1;
		nxt_ext_ack_n = 1'b1;
		if (cyc_active_ff & ~dma_cycle_end_i) begin
			nxt_bus_start_n = (cyc_phase_ff != bs_pos + 2'h1);
			if (cyc_phase_ff > ack_pos) begin
				nxt_int_ack_n = ~cyc_int_ff;
				nxt_ext_ack_n = cyc_int_ff;
			end
		end
	end

	// Strobe outputs, all from flip-flops.
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			fast_page_o <= 1'b0;
			{bus_start_n_o, int_xfer_ack_n_o, ext_xfer_ack_n_o} <= `EDA_RST_STROBE;
		end else begin
			fast_page_o <= nxt_fast_page;
			bus_start_n_o <= nxt_bus_start_n;
			int_xfer_ack_n_o <= nxt_int_ack_n;
			ext_xfer_ack_n_o <= nxt_ext_ack_n;
		end
	end

endmodule

// ### tb/eda_req_properties.sv
// Checker for the request acceptance block: strobe timing and word hold.
// Assumes it is bound to eda_req_accept and registers are written first.
`timescale 1ns/100ps
module eda_req_props (
	input clk_sys_i,
	input srst_i,
	input [3:0] reg_addr_i,
	input [31:0] reg_wdata_i,
	input reg_wr_i,
	input act_valid_o,
	input act_ready_i,
	input [15:0] act_count_o,
	input dma_cycle_start_i,
	input dma_cycle_int_i,
	input dma_cycle_dram_i,
	input dma_cycle_end_i,
	input fast_page_o,
	input bus_start_n_o,
	input int_xfer_ack_n_o,
	input ext_xfer_ack_n_o
);
	reg [2:0] dram_ff;
	reg [1:0] busc_ff;
	reg [1:0] seen_ff;
	reg [2:0] cyc_ff;
	reg [2:0] exp_ff;
	reg unit_ff;
	wire full = dma_cycle_int_i ? dram_ff[1] : dram_ff[2];
	wire late = dma_cycle_int_i ? busc_ff[0] : busc_ff[1];
	wire ok = seen_ff == 2'h3;
	// Shadow settings, and cycles counted from the latest start.
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			seen_ff <= 2'h0;
			cyc_ff <= 3'h7;
		end else begin
			if (reg_wr_i && reg_addr_i == 4'h2) begin
				dram_ff <= reg_wdata_i[2:0];
				seen_ff[0] <= 1'b1;
			end
			if (reg_wr_i && reg_addr_i == 4'h3) begin
				busc_ff <= reg_wdata_i[1:0];
				seen_ff[1] <= 1'b1;
			end
			if (dma_cycle_start_i) begin
				cyc_ff <= 3'h1;
				exp_ff <= 3'h2 + {2'h0, full} + {2'h0, late};
				unit_ff <= dma_cycle_int_i;
			end else if (cyc_ff != 3'h7) begin
				cyc_ff <= cyc_ff + 3'h1;
			end
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	a_page_off: assert property (dma_cycle_start_i && ok && !(dma_cycle_dram_i && dram_ff[0])
		|=> !fast_page_o) else $error("fast page without page mode");
	a_page_select: assert property (dma_cycle_start_i && ok && dma_cycle_dram_i && dram_ff[0]
		|=> fast_page_o != $past(full)) else $error("page choice wrong");
	a_start_fast: assert property (dma_cycle_start_i && ok && !full
		|-> ##1 bus_start_n_o ##1 !bus_start_n_o ##1 bus_start_n_o) else $error("early start");
	a_start_full: assert property (dma_cycle_start_i && ok && full
		|-> ##1 bus_start_n_o [*2] ##1 !bus_start_n_o ##1 bus_start_n_o) else $error("late start");
	a_int_ack_at: assert property ($fell(int_xfer_ack_n_o) && ok
		|-> unit_ff && cyc_ff == exp_ff) else $error("internal ack moment");
	a_ext_ack_at: assert property ($fell(ext_xfer_ack_n_o) && ok
		|-> !unit_ff && cyc_ff == exp_ff) else $error("external ack moment");
	a_ack_release: assert property (dma_cycle_end_i
		|=> int_xfer_ack_n_o && ext_xfer_ack_n_o) else $error("ack kept");
	a_word_holds: assert property (act_valid_o && !act_ready_i
		|=> act_valid_o && $stable(act_count_o)) else $error("word lost");
	a_reset_idle: assert property (disable iff (1'b0) srst_i
		|=> !act_valid_o && bus_start_n_o && int_xfer_ack_n_o) else $error("not idle");
endmodule
bind eda_req_accept eda_req_props u_props (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.act_valid_o(act_valid_o), .act_ready_i(act_ready_i), .act_count_o(act_count_o),
	.dma_cycle_start_i(dma_cycle_start_i), .dma_cycle_int_i(dma_cycle_int_i),
	.dma_cycle_dram_i(dma_cycle_dram_i), .dma_cycle_end_i(dma_cycle_end_i),
	.fast_page_o(fast_page_o), .bus_start_n_o(bus_start_n_o),
	.int_xfer_ack_n_o(int_xfer_ack_n_o), .ext_xfer_ack_n_o(ext_xfer_ack_n_o));

// ### tb/eda_requester.sv
// Model of the external device that asks for transfers on the request pin.
// Assumes go_i is a one-cycle pulse on the bus clock.
`timescale 1ns/100ps
module eda_requester (
	input wire clk_i,
	input wire go_i,
	input wire [7:0] len_i,
	output wire req_n_o
);
	reg [7:0] left_ff = 8'h00;
	// hold line low
	// The pin stays low for len_i cycles, then returns to its pulled-up level.
	always @(posedge clk_i) begin
		if (go_i) begin
			left_ff <= len_i;
		end else if (left_ff != 8'h00) begin
			left_ff <= left_ff - 8'h01;
		end
	end
	// The pin moves off the clock edge, as an unsynchronised device would.
	assign #13 req_n_o = left_ff == 8'h00;
endmodule

// ### tb/test_ext_dma_request_accept.sv
// Bench for the request acceptance block: registers, requests, strobes.
// Assumes the requester model and the checker are compiled before it.
`timescale 1ns/100ps
module test_ext_dma_request_accept;
	reg clk_sys_i = 1'b0;
	reg srst_i = 1'b1;
	reg [3:0] addr = 4'h0;
	reg [31:0] wdata = 32'h0;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg cwe = 1'b0;
	reg rdy = 1'b0;
	reg st = 1'b0;
	reg cint = 1'b0;
	reg cdram = 1'b0;
	reg cend = 1'b0;
	reg go = 1'b0;
	wire [31:0] rdata;
	wire [15:0] acnt;
	wire req_n, av, fp, bs_n, iack_n, eack_n;
	integer n_errors = 0;
	integer checks_done = 0;
	integer i;
	integer k;
	reg [31:0] d;
	initial forever #25 clk_sys_i = ~clk_sys_i;
	eda_req_accept DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
		.ext_xfer_request_n_i(req_n), .cluster_wr_end_i(cwe), .act_valid_o(av),
		.act_ready_i(rdy), .act_count_o(acnt), .dma_cycle_start_i(st),
		.dma_cycle_int_i(cint), .dma_cycle_dram_i(cdram), .dma_cycle_end_i(cend),
		.fast_page_o(fp), .bus_start_n_o(bs_n), .int_xfer_ack_n_o(iack_n),
		.ext_xfer_ack_n_o(eack_n));
	eda_requester u_req (.clk_i(clk_sys_i), .go_i(go), .len_i(8'h08), .req_n_o(req_n));
	// -------
	// Tasks
	// -------
	task final_report;
		begin
			$display("checks %0d errors %0d", checks_done, n_errors);
			if (n_errors == 0 && checks_done > 0) begin
				$display("ALL CHECKS OK");
			end else begin
				$display("CHECKS NOT OK");
			end
			$finish;
		end
	endtask
	task chk(input string name, input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("BAD %s exp %h seen %h", name, exp, seen);
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] v);
		begin
			@(posedge clk_sys_i);
			addr <= a;
			wdata <= v;
			reg_wr <= 1'b1;
			@(posedge clk_sys_i);
			reg_wr <= 1'b0;
		end
	endtask
	// A cluster end pulse when cl is set, then a read of register a in the next cycle.
	task rd(input [3:0] a, input cl);
		begin
			@(posedge clk_sys_i);
			if (cl) begin
				cwe <= 1'b1;
				@(posedge clk_sys_i);
				cwe <= 1'b0;
			end
			addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk_sys_i);
			reg_rd <= 1'b0;
			#1 d = rdata;
		end
	endtask
	task ask;
		begin
			@(posedge clk_sys_i);
			go <= 1'b1;
			@(posedge clk_sys_i);
			go <= 1'b0;
			repeat (14) @(posedge clk_sys_i);
			#1;
		end
	endtask
	task take(input [15:0] c);
		begin
			// Let the edge that moved the buffer head settle before looking.
			#1;
			for (k = 0; k < 40 && av !== 1'b1; k = k + 1) begin
				@(posedge clk_sys_i);
				#1;
			end
			if (av !== 1'b1) begin
				n_errors = n_errors + 1;
				final_report;
			end else begin
				chk("count", {16'h0, acnt}, {16'h0, c});
				@(posedge clk_sys_i);
				rdy <= 1'b1;
				@(posedge clk_sys_i);
				rdy <= 1'b0;
			end
		end
	endtask
	// Bits of c: page, full select, late ack, internal unit, DRAM target.
	task strobe(input [4:0] c);
		integer b;
		integer a;
		begin
			wr(4'h2, {29'h0, c[1], c[1], c[0]});
			wr(4'h3, {30'h0, c[2], c[2]});
			@(posedge clk_sys_i);
			st <= 1'b1;
			cint <= c[3];
			cdram <= c[4];
			@(posedge clk_sys_i);
			st <= 1'b0;
			#1 chk("fast", {31'h0, fp}, {31'h0, c[4] & c[0] & ~c[1]});
			b = 0;
			a = 0;
			for (k = 1; k < 7; k = k + 1) begin
				if (bs_n === 1'b0 && b == 0) b = k;
				if ((c[3] ? iack_n : eack_n) === 1'b0 && a == 0) a = k;
				@(posedge clk_sys_i);
				#1;
			end
			chk("start", b, 2 + c[1]);
			chk("ack", a, 2 + c[1] + c[2]);
			@(posedge clk_sys_i);
			cend <= 1'b1;
			@(posedge clk_sys_i);
			cend <= 1'b0;
			#1 chk("rel", {30'h0, iack_n, eack_n}, 32'h3);
		end
	endtask
	// -------
	// Main sequence
	// -------
	initial begin
		repeat (16) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		wr(4'h4, 32'hffffffff);
		rd(4'h4, 1'b0);
		chk("stat", d, 32'h0);
		rd(4'h9, 1'b0);
		chk("unmap", d, 32'h0);
		ask;
		chk("closed", {31'h0, av}, 32'h0);
		$display("test idle done");
		wr(4'h1, 32'h4);
		wr(4'h0, 32'h1);
		rd(4'h4, 1'b0);
		chk("open", d, 32'h00040005);
		for (i = 0; i < 3; i = i + 1) begin
			ask;
			if (i < 2) rd(4'h4, 1'b1);
			if (i < 2) chk("reopen", d, 32'h00030005 - 32'h00010000 * i);
		end
		rd(4'h4, 1'b0);
		chk("full", d, 32'h00020003);
		for (i = 0; i < 3; i = i + 1) take(16'(4 - i));
		rd(4'h4, 1'b0);
		chk("drain", d, 32'h00020001);
		$display("test buffer done");
		rd(4'h4, 1'b1);
		chk("gap0", d, 32'h00010005);
		ask;
		take(16'h1);
		rd(4'h4, 1'b1);
		chk("done", d, 32'h0);
		ask;
		chk("after", {31'h0, av}, 32'h0);
		wr(4'h1, 32'h2);
		wr(4'h0, 32'h3);
		ask;
		take(16'h2);
		ask;
		rd(4'h4, 1'b0);
		chk("closed1", d, 32'h00020001);
		rd(4'h4, 1'b1);
		chk("gap1a", d, 32'h00010001);
		rd(4'h4, 1'b0);
		chk("gap1b", d, 32'h00010005);
		$display("test delay done");
		for (i = 0; i < 32; i = i + 1) strobe(i[4:0]);
		$display("test strobes done");
		final_report;
	end
endmodule
